//--- rtl/adcs_consts.svh
`ifndef ADCS_CONSTS_SVH
`define ADCS_CONSTS_SVH

// ==========================================
// Instruction word layout
`define ADCS_INSTR_BITS 16
`define ADCS_RW_BIT 15
`define ADCS_L1_BIT 14
`define ADCS_L0_BIT 13
`define ADCS_STREAM_LEN 2'h3

// ==========================================
// Register addresses and transfer command
`define ADCS_ADDR_CFG 8'h00
`define ADCS_ADDR_PWR 8'h08
`define ADCS_ADDR_OUT 8'h14
`define ADCS_ADDR_XFER 8'hff
`define ADCS_XFER_CMD 8'h01

// ==========================================
// Field positions and reset values
`define ADCS_CFG_SDO_EN 0
`define ADCS_CFG_LSB_FIRST 1
`define ADCS_PWR_STBY 5
`define ADCS_OUT_DIS 0
`define ADCS_REG_DEF 8'h00

// ==========================================
// Shift clock made by the host end
`define ADCS_CLK_NS 10
`define ADCS_SCLK_NS 160
`define ADCS_HALF_CYC ((`ADCS_SCLK_NS / 2) / `ADCS_CLK_NS)

`endif

//--- rtl/adcs_pkg.sv
package adcs_pkg;

    // ==========================================
    // Frame states of the device end
    typedef enum logic [1:0] {DS_IDLE, DS_INSTR, DS_DATA} adcs_dev_state_t;

    // ==========================================
    // Sequencer states of the host end
    typedef enum logic [2:0] {HS_IDLE, HS_LEAD, HS_SHIFT, HS_STALL, HS_TAIL} adcs_host_state_t;

endpackage

//--- rtl/adcs_if.sv
`timescale 1ns/1ns

interface adcs_if;
    // Host-driven pins
    logic sclk_drv;
    logic cs_n_drv;
    logic ctl_en;
    logic h_sdio_o;
    logic h_sdio_oe;
    logic reset_pin;
    logic power_down_pin;
    // Device-driven pins
    logic d_sdio_o;
    logic d_sdio_oe;
    logic d_sdo_o;
    logic d_sdo_oe;
    // Resolved wire levels
    logic sclk;
    logic cs_n;
    logic sdio;
    logic serial_data_out;

    // Undriven select floats high, clock and data float low
    assign cs_n = ctl_en ? cs_n_drv : 1'b1;
    assign sclk = ctl_en ? sclk_drv : 1'b0;
    assign sdio = h_sdio_oe ? h_sdio_o : (d_sdio_oe ? d_sdio_o : 1'b0);
    assign serial_data_out = d_sdo_oe ? d_sdo_o : 1'b0;

    modport host (
        output sclk_drv, cs_n_drv, ctl_en, h_sdio_o, h_sdio_oe, reset_pin, power_down_pin,
        input sdio, serial_data_out
    );
    modport dev (
        input sclk, cs_n, sdio, reset_pin, power_down_pin,
        output d_sdio_o, d_sdio_oe, d_sdo_o, d_sdo_oe
    );
endinterface

//--- rtl/adcs_dev.sv
`timescale 1ns/1ns
`include "adcs_consts.svh"

module adcs_dev (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Serial port pins
    adcs_if.dev bus,
    // Converter controls
    output logic power_down_o,
    output logic standby_o,
    output logic drivers_on_o,
    output logic prbs_o,
    output logic datapath_reset_o
);
    import adcs_pkg::*;

    // ==========================================
    // Pin synchronisers
    // Bit order: sclk, cs_n, sdio, reset pin, power-down pin
    logic [4:0] s1_reg;
    logic [4:0] s2_reg;
    logic sclk_d_reg;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            s1_reg <= 5'h02;
            s2_reg <= 5'h02;
            sclk_d_reg <= 1'b0;
        end else begin
            s1_reg <= {bus.power_down_pin, bus.reset_pin, bus.sdio, bus.cs_n, bus.sclk};
            s2_reg <= s1_reg;
            sclk_d_reg <= s2_reg[0];
        end
    end

    logic rise;
    logic fall;
    logic csn;
    logic sdin;
    logic rst_all;

    // Edge detection on the synchronised clock
    assign rise = s2_reg[0] & ~sclk_d_reg;
    assign fall = ~s2_reg[0] & sclk_d_reg;
    assign csn = s2_reg[1];
    assign sdin = s2_reg[2];
    assign rst_all = !nrst_i || s2_reg[3];

    // ==========================================
    // Register space
    logic [7:0] mem [0:255];
    logic [7:0] act_pwr_reg;
    logic [7:0] act_out_reg;
    logic lsb;
    logic sdo_en;

    assign lsb = mem[`ADCS_ADDR_CFG][`ADCS_CFG_LSB_FIRST];
    assign sdo_en = mem[`ADCS_ADDR_CFG][`ADCS_CFG_SDO_EN];

    // ==========================================
    // Frame sequencer
    adcs_dev_state_t state_reg;
    logic [15:0] instr_reg;
    logic [4:0] bit_cnt_reg;
    logic [12:0] addr_reg;
    logic [1:0] left_reg;
    logic stream_reg;
    logic rw_reg;
    logic [7:0] rx_reg;
    logic [15:0] instr_next;
    logic [7:0] rx_next;
    logic [12:0] addr_next;

    // Shift in honouring bit order
    assign instr_next = lsb ? {sdin, instr_reg[15:1]} : {instr_reg[14:0], sdin};
    assign rx_next = lsb ? {sdin, rx_reg[7:1]} : {rx_reg[6:0], sdin};
    // Address walks down in MSB-first, up in LSB-first
    assign addr_next = lsb ? addr_reg + 13'h0001 : addr_reg - 13'h0001;

    always_ff @(posedge clk_i) begin
        if (rst_all) begin
            state_reg <= DS_IDLE;
            instr_reg <= 16'h0000;
            bit_cnt_reg <= 5'h00;
            addr_reg <= 13'h0000;
            left_reg <= 2'h0;
            stream_reg <= 1'b0;
            rw_reg <= 1'b0;
            rx_reg <= 8'h00;
        end else if (csn) begin
            // Select high: hold at byte boundary unless streaming, else drop the frame
            if (state_reg == DS_DATA && bit_cnt_reg == 5'h00 && !stream_reg) begin
                state_reg <= DS_DATA;
            end else begin
                state_reg <= DS_IDLE;
                bit_cnt_reg <= 5'h00;
            end
        end else if (rise) begin
            case (state_reg)
                DS_IDLE: begin
                    // First rising edge with select low opens a frame
                    state_reg <= DS_INSTR;
                    instr_reg <= instr_next;
                    bit_cnt_reg <= 5'h01;
                end
                DS_INSTR: begin
                    instr_reg <= instr_next;
                    if (bit_cnt_reg == 5'(`ADCS_INSTR_BITS - 1)) begin
                        // Decode direction, length and start address
                        state_reg <= DS_DATA;
                        bit_cnt_reg <= 5'h00;
                        rw_reg <= instr_next[`ADCS_RW_BIT];
                        left_reg <= {instr_next[`ADCS_L1_BIT], instr_next[`ADCS_L0_BIT]};
                        stream_reg <= ({instr_next[`ADCS_L1_BIT], instr_next[`ADCS_L0_BIT]}
                            == `ADCS_STREAM_LEN);
                        addr_reg <= instr_next[12:0];
                    end else begin
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                    end
                end
                DS_DATA: begin
                    rx_reg <= rx_next;
                    if (bit_cnt_reg == 5'h07) begin
                        bit_cnt_reg <= 5'h00;
                        addr_reg <= addr_next;
                        if (!stream_reg) begin
                            if (left_reg == 2'h0) begin
                                state_reg <= DS_IDLE;
                            end else begin
                                left_reg <= left_reg - 2'h1;
                            end
                        end
                    end else begin
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                    end
                end
                default: begin
                    state_reg <= DS_IDLE;
                end
            endcase
        end
    end

    // ==========================================
    // Byte write and transfer to active settings
    logic wr_evt;
    logic in_map;

    assign in_map = (addr_reg[12:8] == 5'h00);
    assign wr_evt = !csn && rise && state_reg == DS_DATA && bit_cnt_reg == 5'h07 && !rw_reg;

    // Shadow registers, written only once a byte is complete
    always_ff @(posedge clk_i) begin
        if (rst_all) begin
            for (int i = 0; i < 256; i++) begin
                mem[i] <= `ADCS_REG_DEF;
            end
        end else if (wr_evt && in_map && addr_reg[7:0] != `ADCS_ADDR_XFER) begin
            mem[addr_reg[7:0]] <= rx_next;
        end
    end

    // Active copies updated by the transfer command
    always_ff @(posedge clk_i) begin
        if (rst_all) begin
            act_pwr_reg <= `ADCS_REG_DEF;
            act_out_reg <= `ADCS_REG_DEF;
        end else if (wr_evt && in_map && addr_reg[7:0] == `ADCS_ADDR_XFER
            && rx_next == `ADCS_XFER_CMD) begin
            act_pwr_reg <= mem[`ADCS_ADDR_PWR];
            act_out_reg <= mem[`ADCS_ADDR_OUT];
        end
    end

    // ==========================================
    // Readback driver
    logic rd_phase;
    logic [7:0] rd_byte;
    logic [7:0] tx_reg;
    logic out_bit_reg;
    logic have_bit_reg;
    logic sdio_o_reg;
    logic sdio_oe_reg;
    logic sdo_o_reg;
    logic sdo_oe_reg;

    assign rd_phase = state_reg == DS_DATA && rw_reg;
    assign rd_byte = in_map ? mem[addr_reg[7:0]] : 8'h00;

    // Next read bit launched on the falling edge
    always_ff @(posedge clk_i) begin
        if (rst_all || !rd_phase) begin
            tx_reg <= 8'h00;
            out_bit_reg <= 1'b0;
            have_bit_reg <= 1'b0;
        end else if (fall && !csn) begin
            have_bit_reg <= 1'b1;
            if (bit_cnt_reg == 5'h00) begin
                out_bit_reg <= lsb ? rd_byte[0] : rd_byte[7];
                tx_reg <= lsb ? {1'b0, rd_byte[7:1]} : {rd_byte[6:0], 1'b0};
            end else begin
                out_bit_reg <= lsb ? tx_reg[0] : tx_reg[7];
                tx_reg <= lsb ? {1'b0, tx_reg[7:1]} : {tx_reg[6:0], 1'b0};
            end
        end
    end

    // Pin drivers, released whenever select is high
    always_ff @(posedge clk_i) begin
        if (rst_all) begin
            sdio_o_reg <= 1'b0;
            sdio_oe_reg <= 1'b0;
            sdo_o_reg <= 1'b0;
            sdo_oe_reg <= 1'b0;
        end else begin
            sdio_o_reg <= out_bit_reg;
            sdo_o_reg <= out_bit_reg;
            sdio_oe_reg <= rd_phase && have_bit_reg && !csn && !sdo_en;
            sdo_oe_reg <= rd_phase && have_bit_reg && !csn && sdo_en;
        end
    end

    assign bus.d_sdio_o = sdio_o_reg;
    assign bus.d_sdio_oe = sdio_oe_reg;
    assign bus.d_sdo_o = sdo_o_reg;
    assign bus.d_sdo_oe = sdo_oe_reg;

    // ==========================================
    // Power-down pin handling
    logic pd;
    logic stby_sel;
    logic out_dis;

    assign pd = s2_reg[4];
    assign stby_sel = act_pwr_reg[`ADCS_PWR_STBY];
    assign out_dis = act_out_reg[`ADCS_OUT_DIS];

    // Settings survive power-down; pin level plus active standby and output-disable bits set all outputs but the datapath reset
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            power_down_o <= 1'b0;
            standby_o <= 1'b0;
            drivers_on_o <= 1'b0;
            prbs_o <= 1'b0;
            datapath_reset_o <= 1'b0;
        end else begin
            power_down_o <= pd && !stby_sel;
            standby_o <= pd && stby_sel;
            drivers_on_o <= !(pd && !stby_sel) && !out_dis;
            prbs_o <= pd && stby_sel && !out_dis;
            datapath_reset_o <= s2_reg[3];
        end
    end

endmodule

//--- rtl/adcs_host.sv
`timescale 1ns/1ns
`include "adcs_consts.svh"

module adcs_host (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Serial port pins
    adcs_if.host bus,
    // Command
    input wire logic start_i,
    input wire logic rw_i,
    input wire logic [1:0] len_i,
    input wire logic [12:0] addr_i,
    input wire logic [7:0] wdata_i,
    // Port options
    input wire logic lsb_first_i,
    input wire logic use_sdo_i,
    input wire logic two_wire_i,
    input wire logic stall_i,
    input wire logic stream_end_i,
    input wire logic reset_pin_i,
    input wire logic power_down_i,
    // Answer
    output logic busy_o,
    output logic next_o,
    output logic [7:0] rdata_o,
    output logic rdata_valid_o,
    output logic done_o
);
    import adcs_pkg::*;

    // ==========================================
    // Readback synchroniser
    logic [1:0] s1_reg;
    logic [1:0] s2_reg;
    logic din;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            s1_reg <= 2'h0;
            s2_reg <= 2'h0;
        end else begin
            s1_reg <= {bus.serial_data_out, bus.sdio};
            s2_reg <= s1_reg;
        end
    end

    assign din = use_sdo_i ? s2_reg[1] : s2_reg[0];

    // ==========================================
    // Frame sequencer
    adcs_host_state_t state_reg;
    logic [3:0] cnt_reg;
    logic [4:0] bits_reg;
    logic [15:0] sh_reg;
    logic [7:0] wb_reg;
    logic [7:0] rx_reg;
    logic instr_reg;
    logic rw_reg;
    logic stream_reg;
    logic [1:0] left_reg;
    logic sclk_reg;
    logic csn_reg;
    logic en_reg;
    logic sd_reg;
    logic oe_reg;
    logic half;
    logic last;
    logic fin;

    assign half = (cnt_reg == 4'(`ADCS_HALF_CYC - 1));
    assign last = instr_reg ? (bits_reg == 5'(`ADCS_INSTR_BITS - 1)) : (bits_reg == 5'h07);
    assign fin = stream_reg ? stream_end_i : (left_reg == 2'h0);

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            state_reg <= HS_IDLE;
            cnt_reg <= 4'h0;
            bits_reg <= 5'h00;
            sh_reg <= 16'h0000;
            wb_reg <= 8'h00;
            rx_reg <= 8'h00;
            instr_reg <= 1'b0;
            rw_reg <= 1'b0;
            stream_reg <= 1'b0;
            left_reg <= 2'h0;
            sclk_reg <= 1'b0;
            csn_reg <= 1'b1;
            en_reg <= 1'b0;
            sd_reg <= 1'b0;
            oe_reg <= 1'b0;
            busy_o <= 1'b0;
            next_o <= 1'b0;
            rdata_o <= 8'h00;
            rdata_valid_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            en_reg <= 1'b1;
            next_o <= 1'b0;
            rdata_valid_o <= 1'b0;
            done_o <= 1'b0;
            case (state_reg)
                HS_IDLE: begin
                    csn_reg <= !two_wire_i;
                    sclk_reg <= 1'b0;
                    oe_reg <= 1'b0;
                    // Streaming refused in 2-wire mode
                    if (start_i && !(two_wire_i && len_i == `ADCS_STREAM_LEN)) begin
                        busy_o <= 1'b1;
                        rw_reg <= rw_i;
                        left_reg <= len_i;
                        stream_reg <= (len_i == `ADCS_STREAM_LEN);
                        instr_reg <= 1'b1;
                        bits_reg <= 5'h00;
                        cnt_reg <= 4'h0;
                        csn_reg <= 1'b0;
                        oe_reg <= 1'b1;
                        sd_reg <= lsb_first_i ? addr_i[0] : rw_i;
                        sh_reg <= lsb_first_i ? {1'b0, rw_i, len_i, addr_i[12:1]}
                            : {len_i, addr_i, 1'b0};
                        state_reg <= HS_LEAD;
                    end
                end
                HS_LEAD: begin
                    // Select setup before the first rising edge
                    csn_reg <= 1'b0;
                    cnt_reg <= half ? 4'h0 : cnt_reg + 4'h1;
                    if (half) begin
                        state_reg <= HS_SHIFT;
                    end
                end
                HS_SHIFT: begin
                    cnt_reg <= half ? 4'h0 : cnt_reg + 4'h1;
                    if (half && !sclk_reg) begin
                        // Rising edge: sample readback
                        sclk_reg <= 1'b1;
                        rx_reg <= lsb_first_i ? {din, rx_reg[7:1]} : {rx_reg[6:0], din};
                    end else if (half) begin
                        // Falling edge: launch next bit
                        sclk_reg <= 1'b0;
                        if (!last) begin
                            bits_reg <= bits_reg + 5'h01;
                            if (instr_reg) begin
                                sd_reg <= lsb_first_i ? sh_reg[0] : sh_reg[15];
                                sh_reg <= lsb_first_i ? {1'b0, sh_reg[15:1]}
                                    : {sh_reg[14:0], 1'b0};
                            end else begin
                                sd_reg <= lsb_first_i ? wb_reg[0] : wb_reg[7];
                                wb_reg <= lsb_first_i ? {1'b0, wb_reg[7:1]}
                                    : {wb_reg[6:0], 1'b0};
                            end
                        end else begin
                            bits_reg <= 5'h00;
                            if (!instr_reg && rw_reg) begin
                                rdata_o <= rx_reg;
                                rdata_valid_o <= 1'b1;
                            end
                            if (!instr_reg && fin) begin
                                state_reg <= HS_TAIL;
                            end else begin
                                if (!instr_reg && !stream_reg) begin
                                    left_reg <= left_reg - 2'h1;
                                end
                                instr_reg <= 1'b0;
                                oe_reg <= !rw_reg;
                                if (!rw_reg) begin
                                    next_o <= 1'b1;
                                    sd_reg <= lsb_first_i ? wdata_i[0] : wdata_i[7];
                                    wb_reg <= lsb_first_i ? {1'b0, wdata_i[7:1]}
                                        : {wdata_i[6:0], 1'b0};
                                end
                                if (!instr_reg && stall_i && !stream_reg && !two_wire_i) begin
                                    state_reg <= HS_STALL;
                                end
                            end
                        end
                    end
                end
                HS_STALL: begin
                    // Select high between bytes while stalled
                    csn_reg <= 1'b1;
                    cnt_reg <= half ? 4'h0 : cnt_reg + 4'h1;
                    if (half && !stall_i) begin
                        csn_reg <= 1'b0;
                        state_reg <= HS_LEAD;
                    end
                end
                HS_TAIL: begin
                    cnt_reg <= half ? 4'h0 : cnt_reg + 4'h1;
                    oe_reg <= 1'b0;
                    if (half) begin
                        csn_reg <= !two_wire_i;
                        busy_o <= 1'b0;
                        done_o <= 1'b1;
                        state_reg <= HS_IDLE;
                    end
                end
                default: begin
                    state_reg <= HS_IDLE;
                end
            endcase
        end
    end

    // ==========================================
    // Pin drive, plain levels
    logic rst_pin_reg;
    logic pd_pin_reg;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            rst_pin_reg <= 1'b0;
            pd_pin_reg <= 1'b0;
        end else begin
            rst_pin_reg <= reset_pin_i;
            pd_pin_reg <= power_down_i;
        end
    end

    assign bus.sclk_drv = sclk_reg;
    assign bus.cs_n_drv = csn_reg;
    assign bus.ctl_en = en_reg;
    assign bus.h_sdio_o = sd_reg;
    assign bus.h_sdio_oe = oe_reg;
    assign bus.reset_pin = rst_pin_reg;
    assign bus.power_down_pin = pd_pin_reg;

endmodule

//--- test/adcs_chk_sva.sv
`timescale 1ns/1ns

module adcs_chk (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Link wires
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic h_sdio_oe,
    input wire logic d_sdio_o,
    input wire logic d_sdio_oe,
    input wire logic d_sdo_oe,
    input wire logic reset_pin,
    input wire logic power_down_pin,
    // Converter controls
    input wire logic power_down_o,
    input wire logic standby_o,
    input wire logic drivers_on_o,
    input wire logic prbs_o,
    input wire logic datapath_reset_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    // ==========================================
    // Pin hold sequences
    sequence s_cs_idle; cs_n [*5]; endsequence
    sequence s_pd_hi; power_down_pin [*6]; endsequence
    sequence s_pd_lo; !power_down_pin [*6]; endsequence
    sequence s_rst_hi; reset_pin [*6]; endsequence

    // ==========================================
    // Link checks
    property p_idle_quiet; s_cs_idle |-> !d_sdio_oe && !d_sdo_oe; endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("Drive while deselected");
    property p_drop_oe; $rose(cs_n) |-> ##[1:5] (!d_sdio_oe && !d_sdo_oe); endproperty
    a_drop_oe: assert property (p_drop_oe) else $error("Drive kept after select");
    property p_no_clash; !(h_sdio_oe && d_sdio_oe); endproperty
    a_no_clash: assert property (p_no_clash) else $error("Both ends drive data");
    property p_sdo_excl; !(d_sdio_oe && d_sdo_oe); endproperty
    a_sdo_excl: assert property (p_sdo_excl) else $error("Both outputs on");
    property p_chg_low;
        d_sdio_oe && $changed(d_sdio_o) |-> !sclk && !$past(sclk, 2);
    endproperty
    a_chg_low: assert property (p_chg_low) else $error("Read bit off falling edge");

    // ==========================================
    // Power and reset pin checks
    property p_pd_on; s_pd_hi |-> power_down_o ^ standby_o; endproperty
    a_pd_on: assert property (p_pd_on) else $error("Power pin not obeyed");
    property p_pd_off; s_pd_lo |-> !power_down_o && !standby_o && !prbs_o; endproperty
    a_pd_off: assert property (p_pd_off) else $error("No resume");
    property p_prbs; prbs_o |-> standby_o && drivers_on_o && !power_down_o; endproperty
    a_prbs: assert property (p_prbs) else $error("Pattern outside standby");
    property p_rst_on; s_rst_hi |-> datapath_reset_o; endproperty
    a_rst_on: assert property (p_rst_on) else $error("Reset pin not obeyed");
endmodule

//--- test/tb_adc_serial_control_port.sv
`timescale 1ns/1ns

module tb_adc_serial_control_port;
    import adcs_pkg::*;

    // ==========================================
    // Bench signals
    logic clk_i, nrst_i, start_i, rw_i, lsb_first_i, use_sdo_i, two_wire_i, stall_i;
    logic stream_end_i, reset_pin_i, power_down_i, busy_o, next_o, rdata_valid_o, done_o;
    logic power_down_o, standby_o, drivers_on_o, prbs_o, datapath_reset_o, sclk_q;
    logic [1:0] len_i;
    logic [12:0] addr_i;
    logic [7:0] wdata_i, rdata_o;
    logic [7:0] mem [0:255];
    logic [7:0] wbuf [0:7];
    logic [7:0] exq [$];
    int err_count = 0, n_checks = 0, seed = 77011, cyc = 0, nxt = 0, falls = 0, nn = 1, k;
    int hi = 0;
    bit lsb = 0, stl = 0;

    adcs_if adcs_if_inst ();
    adcs_dev adcs_dev_inst (.clk_i(clk_i), .nrst_i(nrst_i), .bus(adcs_if_inst),
        .power_down_o(power_down_o), .standby_o(standby_o), .drivers_on_o(drivers_on_o),
        .prbs_o(prbs_o), .datapath_reset_o(datapath_reset_o));
    adcs_host adcs_host_inst (.clk_i(clk_i), .nrst_i(nrst_i), .bus(adcs_if_inst),
        .start_i(start_i), .rw_i(rw_i), .len_i(len_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .lsb_first_i(lsb_first_i), .use_sdo_i(use_sdo_i), .two_wire_i(two_wire_i),
        .stall_i(stall_i), .stream_end_i(stream_end_i), .reset_pin_i(reset_pin_i),
        .power_down_i(power_down_i), .busy_o(busy_o), .next_o(next_o), .rdata_o(rdata_o),
        .rdata_valid_o(rdata_valid_o), .done_o(done_o));
    adcs_chk adcs_chk_inst (.clk_i(clk_i), .nrst_i(nrst_i), .sclk(adcs_if_inst.sclk),
        .cs_n(adcs_if_inst.cs_n), .h_sdio_oe(adcs_if_inst.h_sdio_oe),
        .d_sdio_o(adcs_if_inst.d_sdio_o), .d_sdio_oe(adcs_if_inst.d_sdio_oe),
        .d_sdo_oe(adcs_if_inst.d_sdo_oe), .reset_pin(adcs_if_inst.reset_pin),
        .power_down_pin(adcs_if_inst.power_down_pin), .power_down_o(power_down_o),
        .standby_o(standby_o), .drivers_on_o(drivers_on_o), .prbs_o(prbs_o),
        .datapath_reset_o(datapath_reset_o));

    // Clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("Checks made %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Write data feed, edge count, stream end, readback scoreboard, timeout
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        sclk_q <= adcs_if_inst.sclk;
        if (next_o) nxt <= nxt + 1;
        wdata_i <= wbuf[nxt[2:0]];
        if (sclk_q && !adcs_if_inst.sclk) falls <= falls + 1;
        // Stall request drops after select has been high a while
        hi <= adcs_if_inst.cs_n ? hi + 1 : 0;
        stall_i <= stl && hi < 32;
        stream_end_i <= (falls >= 16 + 8 * (nn - 1));
        if (rdata_valid_o && exq.size() == 0) check(rdata_o, ~rdata_o);
        else if (rdata_valid_o) check(rdata_o, exq.pop_front());
        if (cyc == 40000) begin
            err_count++;
            test_done();
        end
    end

    // One command; writes update the image, reads queue their expected bytes
    task automatic cmd(input logic rw, input logic [1:0] len, input logic [12:0] a,
                       input int n, input bit rnd);
        int i;
        logic [12:0] p;
        p = a;
        for (i = 0; i < n; i++) begin
            if (rnd && !rw) wbuf[i] = 8'($random(seed));
            if (!rw && p < 13'h0ff) mem[p[7:0]] = wbuf[i];
            if (rw) exq.push_back(p < 13'h0ff ? mem[p[7:0]] : 8'h00);
            p = lsb ? p + 13'h1 : p - 13'h1;
        end
        nn = n;
        nxt = 0;
        falls = 0;
        @(posedge clk_i);
        rw_i <= rw;
        len_i <= len;
        addr_i <= a;
        start_i <= 1'b1;
        @(posedge clk_i);
        start_i <= 1'b0;
        for (i = 0; i < 4000 && done_o !== 1'b1; i++) @(posedge clk_i);
        check({done_o, busy_o, 6'h0}, 8'h80);
        repeat (8) @(posedge clk_i);
    endtask

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        wbuf[0] = d;
        cmd(1'b0, 2'h0, a, 1, 1'b0);
    endtask

    task automatic pw(input logic pin, input logic [3:0] e);
        power_down_i <= pin;
        repeat (12) @(posedge clk_i);
        check({4'h0, power_down_o, standby_o, drivers_on_o, prbs_o}, {4'h0, e});
    endtask

    // Main sequence
    initial begin
        {nrst_i, start_i, rw_i, lsb_first_i, use_sdo_i, two_wire_i, stall_i} = 7'h0;
        {reset_pin_i, power_down_i, stream_end_i, len_i, addr_i, wdata_i} = 26'h0;
        foreach (mem[j]) mem[j] = 8'h00;
        foreach (wbuf[j]) wbuf[j] = 8'h00;
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        // Lengths one to three, then a stream
        for (k = 0; k < 3; k++) begin
            cmd(1'b0, 2'(k), 13'h040 + 13'(k * 16), k + 1, 1'b1);
            cmd(1'b1, 2'(k), 13'h040 + 13'(k * 16), k + 1, 1'b1);
        end
        cmd(1'b0, 2'h3, 13'h090, 5, 1'b1);
        cmd(1'b1, 2'h3, 13'h090, 5, 1'b1);
        // Select raised between bytes, then a read above the register map
        stl = 1;
        cmd(1'b0, 2'h2, 13'h060, 3, 1'b1);
        cmd(1'b1, 2'h2, 13'h060, 3, 1'b1);
        stl = 0;
        cmd(1'b1, 2'h1, 13'h100, 2, 1'b1);
        // Dedicated output, then least significant bit first
        wr(13'h000, 8'h01);
        use_sdo_i <= 1'b1;
        cmd(1'b1, 2'h1, 13'h041, 2, 1'b1);
        use_sdo_i <= 1'b0;
        wr(13'h000, 8'h02);
        lsb = 1;
        lsb_first_i <= 1'b1;
        cmd(1'b0, 2'h3, 13'h050, 3, 1'b1);
        cmd(1'b1, 2'h3, 13'h050, 3, 1'b1);
        wr(13'h000, 8'h00);
        lsb = 0;
        lsb_first_i <= 1'b0;
        // Select held low
        two_wire_i <= 1'b1;
        cmd(1'b0, 2'h1, 13'h071, 2, 1'b1);
        cmd(1'b1, 2'h1, 13'h071, 2, 1'b1);
        two_wire_i <= 1'b0;
        // Power pin modes and transfer
        pw(1'b1, 4'b1000);
        pw(1'b0, 4'b0010);
        wr(13'h008, 8'h20);
        pw(1'b1, 4'b1000);
        pw(1'b0, 4'b0010);
        wr(13'h0ff, 8'h01);
        pw(1'b1, 4'b0111);
        pw(1'b0, 4'b0010);
        wr(13'h014, 8'h01);
        wr(13'h0ff, 8'h01);
        pw(1'b1, 4'b0100);
        pw(1'b0, 4'b0000);
        cmd(1'b1, 2'h0, 13'h008, 1, 1'b1);
        // Reset pin
        reset_pin_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        check({7'h0, datapath_reset_o}, 8'h01);
        reset_pin_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        foreach (mem[j]) mem[j] = 8'h00;
        pw(1'b0, 4'b0010);
        cmd(1'b1, 2'h1, 13'h014, 2, 1'b1);
        check(8'(exq.size()), 8'h00);
        test_done();
    end
endmodule
